//--- pkg/ces_regs.svh
// Register map, field positions and reset values of the comparator event slice.
// Assumes inclusion by bare name from the package and the design files.
`ifndef CES_REGS_SVH
`define CES_REGS_SVH

// ----------------------------------------------------------------------------
// Bus geometry
// ----------------------------------------------------------------------------
`define CES_ADDR_W 8
`define CES_DATA_W 32
`define CES_CTRL_OFS 8'h00

// ----------------------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------------------
`define CES_INV_BIT 13
`define CES_MODE_BIT 10
`define CES_FLAG_BIT 9
`define CES_RES_BIT 8
`define CES_EVPOL_LSB 6
`define CES_REF_BIT 4
`define CES_CHAN_LSB 0
`define CES_CTRL_RST 16'h0000

// ----------------------------------------------------------------------------
// Bus response codes
// ----------------------------------------------------------------------------
`define CES_RESP_OKAY 2'h0
`define CES_RESP_SLVERR 2'h2

`endif

//--- pkg/ces_pkg.sv
// Types shared by the comparator event slice.
// Assumes the register header sits beside it on the include path.
`include "ces_regs.svh"

package ces_pkg;

    // ------------------------------------------------------------------------
    // Field encodings
    // ------------------------------------------------------------------------
    typedef enum logic [1:0] {
        CES_EV_OFF  = 2'b00,
        CES_EV_RISE = 2'b01,
        CES_EV_FALL = 2'b10,
        CES_EV_ANY  = 2'b11
    } ces_evpol_e;

    typedef enum logic [1:0] {
        CES_CH_PIN_ONE = 2'b00,
        CES_CH_PIN_TWO = 2'b01,
        CES_CH_RSV_A   = 2'b10,
        CES_CH_RSV_B   = 2'b11
    } ces_chan_e;

endpackage

//--- hw/ces_sync.sv
// Two-stage synchroniser for a level from outside the clock domain.
// Assumes the input may change at any time relative to ref_clk.
`timescale 1ns/100ps

module ces_sync (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic async_in,
    output logic sync_out
);

    logic meta_q;

    // ------------------------------------------------------------------------
    // Only the second stage reads the first.
    // ------------------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= 1'b0;
            sync_out <= 1'b0;
        end else begin
            meta_q <= async_in;
            sync_out <= meta_q;
        end
    end

endmodule

//--- hw/ces_event_select.sv
// Digital control slice of one comparator channel: input source selection,
// output polarity and event detection, with an AXI4-Lite register port.
// Assumes an analog core whose raw result arrives asynchronously.
`timescale 1ns/100ps
`include "ces_regs.svh"

module ces_event_select
    import ces_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [`CES_ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [`CES_DATA_W-1:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [`CES_ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [`CES_DATA_W-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic comparator_result,
    output logic plus_sel_reference,
    output logic plus_sel_pin_one,
    output logic minus_sel_pin_one,
    output logic minus_sel_pin_two,
    output logic amplifier_mode,
    output logic event_trigger,
    output logic event_occurred_flag
);

    // ------------------------------------------------------------------------
    // Control state
    // ------------------------------------------------------------------------
    logic output_invert_sel_q;
    logic amplifier_mode_sel_q;
    logic event_flag_q;
    ces_evpol_e event_polarity_sel_q;
    logic plus_reference_sel_q;
    ces_chan_e minus_channel_sel_q;
    logic res_sync;
    logic res_prev_q;
    logic result_adj_q;
    logic trigger_q;

    logic aw_hold_q;
    logic [`CES_ADDR_W-1:0] aw_addr_q;
    logic w_hold_q;
    logic [15:0] w_data_q;
    logic [1:0] w_strb_q;
    logic do_wr;
    logic ctrl_wr;
    logic raw_rise;
    logic raw_fall;
    logic adj_rise;
    logic adj_fall;
    logic qualify;

    function automatic logic ctrl_hit(input logic [`CES_ADDR_W-1:0] addr);
        ctrl_hit = (addr == `CES_CTRL_OFS);
    endfunction

    function automatic logic [15:0] ctrl_pack();
        logic [15:0] v;
        v = `CES_CTRL_RST;
        v[`CES_INV_BIT] = output_invert_sel_q;
        v[`CES_MODE_BIT] = amplifier_mode_sel_q;
        v[`CES_FLAG_BIT] = event_flag_q;
        v[`CES_RES_BIT] = result_adj_q;
        v[`CES_EVPOL_LSB +: 2] = event_polarity_sel_q;
        v[`CES_REF_BIT] = plus_reference_sel_q;
        v[`CES_CHAN_LSB +: 2] = minus_channel_sel_q;
        ctrl_pack = v;
    endfunction

    // ------------------------------------------------------------------------
    // Result synchronisation and edge detection
    // ------------------------------------------------------------------------
    ces_sync u_sync (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .async_in(comparator_result),
        .sync_out(res_sync)
    );

    // Edges are taken on the raw level and then mapped through the invert
    // select, so toggling the invert bit alone never looks like an edge.
    assign raw_rise = res_sync & ~res_prev_q;
    assign raw_fall = ~res_sync & res_prev_q;
    assign adj_rise = output_invert_sel_q ? raw_fall : raw_rise;
    assign adj_fall = output_invert_sel_q ? raw_rise : raw_fall;

    always_comb begin
        unique case (event_polarity_sel_q)
            CES_EV_ANY: qualify = raw_rise | raw_fall;
            CES_EV_FALL: qualify = adj_fall;
            CES_EV_RISE: qualify = adj_rise;
            CES_EV_OFF: qualify = 1'b0;
        endcase
        qualify = qualify & ~event_flag_q;
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            res_prev_q <= 1'b0;
            result_adj_q <= 1'b0;
            trigger_q <= 1'b0;
        end else begin
            res_prev_q <= res_sync;
            result_adj_q <= res_sync ^ output_invert_sel_q;
            trigger_q <= qualify;
        end
    end

    // ------------------------------------------------------------------------
    // Event flag: a new event wins over a clear in the same cycle
    // ------------------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            event_flag_q <= 1'b0;
        end else if (qualify) begin
            event_flag_q <= 1'b1;
        end else if (ctrl_wr && w_strb_q[1] && !w_data_q[`CES_FLAG_BIT]) begin
            event_flag_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------------------
    // Control register fields
    // ------------------------------------------------------------------------
    assign do_wr = aw_hold_q & w_hold_q & ~s_axi_bvalid;
    assign ctrl_wr = do_wr & ctrl_hit(aw_addr_q);

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            output_invert_sel_q <= 1'b0;
            amplifier_mode_sel_q <= 1'b0;
            event_polarity_sel_q <= CES_EV_OFF;
            plus_reference_sel_q <= 1'b0;
            minus_channel_sel_q <= CES_CH_PIN_ONE;
        end else if (ctrl_wr) begin
            // Bits 15:14, 12:11, 5 and 3:2 have no storage.
            if (w_strb_q[1]) begin
                output_invert_sel_q <= w_data_q[`CES_INV_BIT];
                amplifier_mode_sel_q <= w_data_q[`CES_MODE_BIT];
            end
            if (w_strb_q[0]) begin
                event_polarity_sel_q <= ces_evpol_e'(w_data_q[`CES_EVPOL_LSB +: 2]);
                plus_reference_sel_q <= w_data_q[`CES_REF_BIT];
                minus_channel_sel_q <= ces_chan_e'(w_data_q[`CES_CHAN_LSB +: 2]);
            end
        end
    end

    // ------------------------------------------------------------------------
    // Analog source selection; all zero ties the input to ground
    // ------------------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            plus_sel_reference <= 1'b0;
            plus_sel_pin_one <= 1'b0;
            minus_sel_pin_one <= 1'b0;
            minus_sel_pin_two <= 1'b0;
            amplifier_mode <= 1'b0;
        end else begin
            plus_sel_reference <= plus_reference_sel_q & ~amplifier_mode_sel_q;
            plus_sel_pin_one <= ~plus_reference_sel_q;
            minus_sel_pin_one <= (minus_channel_sel_q == CES_CH_PIN_ONE);
            minus_sel_pin_two <= (minus_channel_sel_q == CES_CH_PIN_TWO)
                & ~amplifier_mode_sel_q;
            amplifier_mode <= amplifier_mode_sel_q;
        end
    end

    assign event_trigger = trigger_q;
    assign event_occurred_flag = event_flag_q;

    // ------------------------------------------------------------------------
    // AXI4-Lite write channel
    // ------------------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            aw_hold_q <= 1'b0;
            aw_addr_q <= '0;
            s_axi_awready <= 1'b1;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_hold_q <= 1'b1;
            aw_addr_q <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
        end else if (do_wr) begin
            aw_hold_q <= 1'b0;
        end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_awready <= 1'b1;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            w_hold_q <= 1'b0;
            w_data_q <= '0;
            w_strb_q <= '0;
            s_axi_wready <= 1'b1;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_hold_q <= 1'b1;
            w_data_q <= s_axi_wdata[15:0];
            w_strb_q <= s_axi_wstrb[1:0];
            s_axi_wready <= 1'b0;
        end else if (do_wr) begin
            w_hold_q <= 1'b0;
        end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_wready <= 1'b1;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `CES_RESP_OKAY;
        end else if (do_wr) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= ctrl_hit(aw_addr_q) ? `CES_RESP_OKAY : `CES_RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // ------------------------------------------------------------------------
    // AXI4-Lite read channel
    // ------------------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= `CES_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            if (ctrl_hit(s_axi_araddr)) begin
                s_axi_rdata <= {16'h0000, ctrl_pack()};
                s_axi_rresp <= `CES_RESP_OKAY;
            end else begin
                s_axi_rdata <= '0;
                s_axi_rresp <= `CES_RESP_SLVERR;
            end
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    // ------------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------------
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);

    sequence s_armed;
        !event_flag_q;
    endsequence

    // A clear followed at once by a fresh edge may legally fire again two
    // cycles on, so only the cycle right after the pulse must be low.
    sequence s_fire_then_block;
        trigger_q ##1 !trigger_q;
    endsequence

    AST_ANY_EDGE: assert property (
        (event_polarity_sel_q == CES_EV_ANY) and s_armed and (res_sync != res_prev_q)
        |=> trigger_q)
        else $error("change in any-edge mode gave no trigger");
    AST_FALL_ONLY: assert property (
        (event_polarity_sel_q == CES_EV_FALL) and s_armed
        and ((res_sync ^ output_invert_sel_q) < (res_prev_q ^ output_invert_sel_q))
        |=> trigger_q)
        else $error("adjusted falling edge gave no trigger");
    AST_RISE_ONLY: assert property (
        (event_polarity_sel_q == CES_EV_RISE) and (res_sync == output_invert_sel_q)
        |=> !trigger_q)
        else $error("trigger without adjusted rising edge");
    AST_OFF: assert property (
        event_polarity_sel_q == CES_EV_OFF |=> !trigger_q)
        else $error("trigger while events disabled");
    AST_BLOCKED: assert property (
        event_flag_q |=> !trigger_q)
        else $error("trigger while event flag set");
    AST_FLAG_SET: assert property (
        trigger_q |-> event_flag_q ##1 (event_flag_q || $past(ctrl_wr)))
        else $error("trigger without event flag");
    AST_ONE_PULSE: assert property (
        $rose(trigger_q) |-> s_fire_then_block)
        else $error("trigger longer than one cycle");
    AST_INVERT: assert property (
        ##1 result_adj_q == ($past(res_sync) ^ $past(output_invert_sel_q)))
        else $error("status result ignores invert select");
    AST_OPAMP: assert property (
        amplifier_mode_sel_q |=> !plus_sel_reference && !minus_sel_pin_two)
        else $error("unavailable input selected in op amp mode");
    AST_PLUS_SEL: assert property (
        plus_reference_sel_q && !amplifier_mode_sel_q |=> plus_sel_reference && !plus_sel_pin_one)
        else $error("reference not routed to plus input");
    AST_MINUS_SEL: assert property (
        minus_channel_sel_q == CES_CH_PIN_ONE |=> minus_sel_pin_one && !minus_sel_pin_two)
        else $error("minus pin one not selected");
    AST_UNUSED_BITS: assert property (
        s_axi_rvalid |-> (s_axi_rdata[5] == 1'b0) && (s_axi_rdata[3:2] == 2'b00))
        else $error("unimplemented bit read as one");

endmodule

//--- verif/ces_core_model.sv
// Behavioural analog comparator core with its input multiplexers.
// Assumes select lines from the event slice and input levels from the bench.
`timescale 1ns/100ps

module ces_core_model #(
    parameter int SETTLE_NS = 0
) (
    input wire logic plus_sel_reference,
    input wire logic plus_sel_pin_one,
    input wire logic minus_sel_pin_one,
    input wire logic minus_sel_pin_two,
    input wire logic [7:0] reference_lvl,
    input wire logic [7:0] plus_one_lvl,
    input wire logic [7:0] minus_one_lvl,
    input wire logic [7:0] minus_two_lvl,
    output logic comparator_result
);
    logic [7:0] plus_v;
    logic [7:0] minus_v;

    // An input that nothing selects sits at ground.
    assign plus_v = plus_sel_reference ? reference_lvl :
                    (plus_sel_pin_one ? plus_one_lvl : 8'h00);
    assign minus_v = minus_sel_pin_one ? minus_one_lvl :
                     (minus_sel_pin_two ? minus_two_lvl : 8'h00);
    assign #(SETTLE_NS) comparator_result = (plus_v > minus_v);
endmodule

//--- verif/ces_event_select_tb.sv
// Self-checking bench for the comparator event slice over its register port.
// Assumes the analog core model in its own file and the register header.
`timescale 1ns/100ps
`include "ces_regs.svh"

module ces_event_select_tb;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00;
    logic [7:0] s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'h0;
    logic s_axi_awvalid = 1'b0;
    logic s_axi_wvalid = 1'b0;
    logic s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0;
    logic s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    logic comparator_result, plus_sel_reference, plus_sel_pin_one, minus_sel_pin_one;
    logic minus_sel_pin_two, amplifier_mode, event_trigger, event_occurred_flag;
    logic [7:0] reference_lvl = 8'h50;
    logic [7:0] plus_one_lvl = 8'h10;
    logic [7:0] minus_one_lvl = 8'h40;
    logic [7:0] minus_two_lvl = 8'h30;
    int n_mismatch = 0;
    int total_checks = 0;
    int trig_cnt = 0;

    always #4 ref_clk = ~ref_clk;

    always @(posedge ref_clk) if (event_trigger === 1'b1) trig_cnt++;

    ces_event_select dut_u (
        .ref_clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .comparator_result,
        .plus_sel_reference, .plus_sel_pin_one, .minus_sel_pin_one, .minus_sel_pin_two,
        .amplifier_mode, .event_trigger, .event_occurred_flag
    );

    ces_core_model #(.SETTLE_NS(13)) core_u (
        .plus_sel_reference, .plus_sel_pin_one, .minus_sel_pin_one, .minus_sel_pin_two,
        .reference_lvl, .plus_one_lvl, .minus_one_lvl, .minus_two_lvl, .comparator_result
    );

    // ------------------------------------------------------------------------
    // Bus tasks and comparison
    // ------------------------------------------------------------------------
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                          output logic [1:0] r);
        int n;
        r = 2'bxx;
        @(posedge ref_clk);
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (n = 0; n < 64; n++) begin
            @(posedge ref_clk);
            if (s_axi_awvalid && s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid === 1'b1) begin
                r = s_axi_bresp;
                s_axi_bready <= 1'b0;
                break;
            end
        end
        if (n == 64) begin
            n_mismatch++;
            tally_and_finish();
        end
    endtask

    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        d = 32'hx;
        r = 2'bxx;
        @(posedge ref_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (n = 0; n < 64; n++) begin
            @(posedge ref_clk);
            if (s_axi_arvalid && s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid === 1'b1) begin
                d = s_axi_rdata;
                r = s_axi_rresp;
                s_axi_rready <= 1'b0;
                break;
            end
        end
        if (n == 64) begin
            n_mismatch++;
            tally_and_finish();
        end
    endtask

    // ------------------------------------------------------------------------
    // Event expectation and edge scenarios
    // ------------------------------------------------------------------------
    function automatic logic fires(input logic [1:0] ev, input logic inv, input logic rise);
        case (ev)
            2'b11: return 1'b1;
            2'b01: return rise ^ inv;
            2'b10: return ~(rise ^ inv);
            default: return 1'b0;
        endcase
    endfunction

    task automatic edge_pair(input logic [1:0] ev, input logic inv);
        logic [1:0] r;
        logic [31:0] d;
        logic [31:0] cfg;
        logic f;
        int e;
        cfg = {18'h0, inv, 5'h0, ev, 6'h0};
        for (e = 0; e < 2; e++) begin
            axi_wr(`CES_CTRL_OFS, cfg, 4'h3, r);
            repeat (8) @(posedge ref_clk);
            @(negedge ref_clk);
            trig_cnt = 0;
            @(posedge ref_clk);
            plus_one_lvl <= (e == 0) ? 8'h70 : 8'h10;
            repeat (10) @(posedge ref_clk);
            f = fires(ev, inv, e == 0);
            chk(32'(trig_cnt), {31'h0, f});
            chk({31'h0, event_occurred_flag}, {31'h0, f});
            axi_rd(`CES_CTRL_OFS, d, r);
            chk(d, cfg | {22'h0, f, (e == 0) ^ inv, 8'h0});
        end
    endtask

    // ------------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------------
    initial begin
        logic [1:0] r;
        logic [31:0] d;
        logic [15:0] cfg;
        int i;
        repeat (2) @(posedge ref_clk);
        rst_n <= 1'b1;
        axi_rd(`CES_CTRL_OFS, d, r);
        chk(d, {16'h0, `CES_CTRL_RST});
        chk({30'h0, r}, {30'h0, `CES_RESP_OKAY});
        axi_wr(`CES_CTRL_OFS, 32'hffff_ffff, 4'hf, r);
        chk({30'h0, r}, {30'h0, `CES_RESP_OKAY});
        axi_rd(`CES_CTRL_OFS, d, r);
        chk(d & ~32'h100, 32'h24d3);
        axi_wr(`CES_CTRL_OFS, 32'h0, 4'h1, r);
        axi_rd(`CES_CTRL_OFS, d, r);
        chk(d & ~32'h100, 32'h2400);
        axi_rd(8'h04, d, r);
        chk({d[29:0], r}, {30'h0, `CES_RESP_SLVERR});
        axi_wr(8'h04, 32'hffff_ffff, 4'hf, r);
        chk({30'h0, r}, {30'h0, `CES_RESP_SLVERR});
        axi_rd(`CES_CTRL_OFS, d, r);
        chk(d & ~32'h100, 32'h2400);
        for (i = 0; i < 16; i++) begin
            cfg = {5'h0, i[3], 5'h0, i[2], 2'h0, i[1:0]};
            axi_wr(`CES_CTRL_OFS, {16'h0, cfg}, 4'h3, r);
            repeat (2) @(posedge ref_clk);
            chk({27'h0, plus_sel_reference, plus_sel_pin_one, minus_sel_pin_one,
                 minus_sel_pin_two, amplifier_mode}, {27'h0, i[2] & ~i[3], ~i[2],
                 i[1:0] == 2'b00, i[1:0] == 2'b01 && !i[3],
                 i[3]});
        end
        axi_wr(`CES_CTRL_OFS, 32'h0011, 4'h3, r);
        repeat (8) @(posedge ref_clk);
        axi_rd(`CES_CTRL_OFS, d, r);
        chk(d, 32'h0111);
        axi_wr(`CES_CTRL_OFS, 32'h0411, 4'h3, r);
        repeat (8) @(posedge ref_clk);
        axi_rd(`CES_CTRL_OFS, d, r);
        chk(d, 32'h0411);
        axi_wr(`CES_CTRL_OFS, 32'h0, 4'h3, r);
        repeat (8) @(posedge ref_clk);
        for (i = 0; i < 8; i++) edge_pair(i[1:0], i[2]);
        axi_wr(`CES_CTRL_OFS, 32'h00c0, 4'h3, r);
        repeat (8) @(posedge ref_clk);
        @(negedge ref_clk);
        trig_cnt = 0;
        @(posedge ref_clk);
        plus_one_lvl <= 8'h70;
        repeat (10) @(posedge ref_clk);
        plus_one_lvl <= 8'h10;
        repeat (10) @(posedge ref_clk);
        chk(32'(trig_cnt), 32'h1);
        chk({31'h0, event_occurred_flag}, 32'h1);
        tally_and_finish();
    end
endmodule
